// [hdl/dram_async_ctrl.sv]
// controller driving a 256k x 1 asynchronous memory over its pins
// assumes the memory data output is synchronised here; one clock only
// refresh rides on re-running the eight init pulses after an idle
// spell; a steady stream of accesses refreshes only the rows it opens
module dram_async_ctrl
    import dram_timing_pkg::*;
#(
    parameter int POWERUP_COUNT = POWERUP_CYC,
    parameter int IDLE_COUNT    = IDLE_CYC
) (
    input  wire logic              mclk,
    input  wire logic              rst_b,
    input  wire logic              req_valid,
    input  wire logic              req_write,
    input  wire logic [17:0]       req_addr,
    input  wire logic              req_wdata,
    output logic                   req_ready,
    output logic                   rsp_valid,
    output logic                   rsp_rdata,
    output logic                   init_done,
    output logic                   ras_b,
    output logic                   cas_b,
    output logic                   we_b,
    output logic [ADDR_W-1:0]      muxed_address,
    output logic                   din,
    input  wire logic              dout
);
    // refuse counts that the 24-bit wait and idle counters cannot hold
    if (POWERUP_COUNT < 1 || POWERUP_COUNT >= (1 << 24)) begin : g_up
        $error("POWERUP_COUNT out of range");
    end
    if (IDLE_COUNT < 8 || IDLE_COUNT >= (1 << 24)) begin : g_idle
        $error("IDLE_COUNT out of range");
    end

    // the init pulse counter is four bits wide
    if (INIT_CYCLES < 1 || INIT_CYCLES > 15) begin : g_init
        $error("INIT_CYCLES out of range");
    end

    // the gap after an init pulse would count below zero
    if (CYCLE_CYC < RAS_LOW_CYC) begin : g_cyc
        $error("CYCLE_CYC below RAS_LOW_CYC");
    end

    // every strobe phase needs at least one whole cycle
    if (RAS_LOW_CYC < 1 || ROW_CYC < 1 || RAS_PRE_CYC < 1) begin : g_ph
        $error("strobe phase below one cycle");
    end

    // read data crosses two flip-flops and the column strobe has a
    // least width, so the access wait may not be shorter than either
    if (ACC_CYC < 2 || ACC_CYC < CAS_LOW_CYC) begin : g_acc
        $error("ACC_CYC too short");
    end

    // row and column halves together make the 18-bit request address
    if (2 * ADDR_W != 18) begin : g_addr
        $error("ADDR_W does not halve the request address");
    end

    // true once a wait count has run down
    function automatic logic wait_over(input logic [23:0] count);
        return count == 24'h000000;
    endfunction

    typedef enum logic [3:0] {
        S_POWERUP = 4'h0,
        S_INIT_LO = 4'h1,
        S_INIT_HI = 4'h2,
        S_IDLE    = 4'h3,
        S_ROW     = 4'h4,
        S_COL     = 4'h5,
        S_CAS     = 4'h6,
        S_END     = 4'h7,
        S_PRE     = 4'h8
    } state_type;

    state_type          state_reg, state_next;
    logic [23:0]        wait_reg, wait_next;
    logic [23:0]        idle_reg, idle_next;
    logic [3:0]         init_reg, init_next;
    logic               ras_reg, ras_next;
    logic               cas_reg, cas_next;
    logic               we_reg, we_next;
    logic [ADDR_W-1:0]  addr_reg, addr_next;
    logic               din_reg, din_next;
    logic               ready_reg, ready_next;
    logic               rv_reg, rv_next;
    logic               rd_reg, rd_next;
    logic               done_reg, done_next;
    logic               wr_reg, wr_next;
    logic [ADDR_W-1:0]  col_reg, col_next;
    logic               dout_s1_reg, dout_s2_reg;
    logic               idle_over;
    logic               take;

    // data pin from the memory is asynchronous to mclk
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            dout_s1_reg <= 1'b0;
            dout_s2_reg <= 1'b0;
        end else begin
            dout_s1_reg <= dout;
            dout_s2_reg <= dout_s1_reg;
        end
    end

    always_comb begin
        state_next = state_reg;
        wait_next  = wait_over(wait_reg) ? wait_reg
                                         : wait_reg - 24'h000001;
        init_next  = init_reg;
        ras_next   = ras_reg;
        cas_next   = cas_reg;
        we_next    = we_reg;
        addr_next  = addr_reg;
        din_next   = din_reg;
        ready_next = 1'b0;
        done_next  = done_reg;
        wr_next    = wr_reg;
        col_next   = col_reg;
        unique case (state_reg)
            S_POWERUP: begin
                if (wait_over(wait_reg)) begin
                    init_next  = 4'h0;
                    state_next = S_INIT_LO;
                end
            end
            S_INIT_LO: begin
                if (wait_over(wait_reg)) begin
                    ras_next   = 1'b0;
                    wait_next  = 24'(RAS_LOW_CYC - 1);
                    state_next = S_INIT_HI;
                end
            end
            S_INIT_HI: begin
                if (wait_over(wait_reg)) begin
                    ras_next  = 1'b1;
                    wait_next = 24'(CYCLE_CYC - RAS_LOW_CYC);
                    init_next = init_reg + 4'h1;
                    if (init_reg == 4'(INIT_CYCLES - 1)) begin
                        state_next = S_PRE;
                        done_next  = 1'b1;
                    end else begin
                        state_next = S_INIT_LO;
                    end
                end
            end
            S_IDLE: begin
                if (idle_over) begin
                    done_next  = 1'b0;
                    init_next  = 4'h0;
                    state_next = S_INIT_LO;
                end else if (take) begin
                    wr_next    = req_write;
                    din_next   = req_wdata;
                    col_next   = req_addr[17:9];
                    addr_next  = req_addr[8:0];
                    // write strobe high before row fall
                    we_next    = 1'b1;
                    state_next = S_ROW;
                end else begin
                    // ready falls a cycle before a re-init, so no
                    // offer is lost to the refresh
                    ready_next = (idle_reg < 24'(IDLE_COUNT - 2));
                end
            end
            S_ROW: begin
                // row address set up one cycle ahead
                ras_next   = 1'b0;
                wait_next  = 24'(ROW_CYC - 1);
                state_next = S_COL;
            end
            S_COL: begin
                if (wait_over(wait_reg)) begin
                    // row held a full cycle; column follows
                    addr_next  = col_reg;
                    we_next    = !wr_reg;
                    state_next = S_CAS;
                end
            end
            S_CAS: begin
                // column and write strobe settled a cycle early
                cas_next   = 1'b0;
                wait_next  = 24'(ACC_CYC);
                state_next = S_END;
            end
            S_END: begin
                if (wait_over(wait_reg)) begin
                    // read bit is caught by the answer group below
                    ras_next   = 1'b1;
                    cas_next   = 1'b1;
                    wait_next  = 24'(RAS_PRE_CYC);
                    state_next = S_PRE;
                end
            end
            S_PRE: begin
                if (wait_over(wait_reg)) begin
                    // write strobe raised only after strobes
                    we_next    = 1'b1;
                    ready_next = done_reg;
                    state_next = S_IDLE;
                end
            end
            default: begin
                state_next = S_POWERUP;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= S_POWERUP;
            wait_reg  <= 24'(POWERUP_COUNT);
            init_reg  <= 4'h0;
            ras_reg   <= 1'b1;
            cas_reg   <= 1'b1;
            we_reg    <= 1'b1;
            addr_reg  <= 9'h000;
            din_reg   <= 1'b0;
            ready_reg <= 1'b0;
            done_reg  <= 1'b0;
            wr_reg    <= 1'b0;
            col_reg   <= 9'h000;
        end else begin
            state_reg <= state_next;
            wait_reg  <= wait_next;
            init_reg  <= init_next;
            ras_reg   <= ras_next;
            cas_reg   <= cas_next;
            we_reg    <= we_next;
            addr_reg  <= addr_next;
            din_reg   <= din_next;
            ready_reg <= ready_next;
            done_reg  <= done_next;
            wr_reg    <= wr_next;
            col_reg   <= col_next;
        end
    end

    assign idle_over = (idle_reg >= 24'(IDLE_COUNT - 1));
    // a take needs ready already standing at the edge
    assign take      = req_valid && ready_reg;

    // idle run length; only the idle state lets it grow, and a
    // take or a re-init starts it again from zero
    always_comb begin
        idle_next = 24'h000000;
        if (state_reg == S_IDLE && !idle_over && !take) begin
            idle_next = idle_reg + 24'h000001;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            idle_reg <= 24'h000000;
        end else begin
            idle_reg <= idle_next;
        end
    end

    // read answer: one-cycle pulse as the strobes rise; the bit is
    // kept across writes, which leave the memory output undriven
    always_comb begin
        rv_next = 1'b0;
        rd_next = rd_reg;
        if (state_reg == S_END && wait_over(wait_reg) && !wr_reg) begin
            rv_next = 1'b1;
            rd_next = dout_s2_reg;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rv_reg <= 1'b0;
            rd_reg <= 1'b0;
        end else begin
            rv_reg <= rv_next;
            rd_reg <= rd_next;
        end
    end

    assign req_ready     = ready_reg;
    assign rsp_valid     = rv_reg;
    assign rsp_rdata     = rd_reg;
    assign init_done     = done_reg;
    assign ras_b         = ras_reg;
    assign cas_b         = cas_reg;
    assign we_b          = we_reg;
    assign muxed_address = addr_reg;
    assign din           = din_reg;
endmodule

// [hdl/dram_timing_pkg.sv]
// constants for the 256k x 1 asynchronous memory controller
// assumes a 10 MHz mclk; every time the controller uses is converted to whole clock cycles
// Summary of operation
// - wait 100 us, then eight strobe cycles
// - idle over 4 ms needs eight cycles again
// - row strobe falls at least 200 ns apart
// - row-to-column 95 ns max is reference only
// - write strobe high before column strobe falls
// - write strobe high after column strobe rises
// - or write strobe high 10 ns past row rise
// - hold row address 15 ns after row fall
// - column address 5 ns before column fall
// - hold column address 15/60 ns
// - column address 55 ns before row rise
// - write strobe high 10 ns before row fall
package dram_timing_pkg;
    localparam int CLK_NS           = 100;
    localparam int POWERUP_US       = 100;
    localparam int INIT_CYCLES      = 8;
    localparam int IDLE_LIMIT_MS    = 4;
    localparam int CYCLE_MIN_NS     = 200;
    localparam int RAS_WIDTH_MIN_NS = 120;
    localparam int RAS_PRE_MIN_NS   = 70;
    localparam int RAS_CAS_MIN_NS   = 30;
    localparam int ROW_HOLD_NS      = 15;
    localparam int COL_SETUP_NS     = 5;
    localparam int ACCESS_RAS_NS    = 120;
    localparam int ACCESS_CAS_NS    = 25;
    localparam int ACCESS_COL_NS    = 55;
    localparam int COL_TO_RAS_UP_NS = 55;
    localparam int CAS_WIDTH_MIN_NS = 25;
    // least times round up, never below one cycle
    localparam int POWERUP_CYC = (POWERUP_US * 1000 + CLK_NS - 1) / CLK_NS;
    // longest time rounds down
    localparam int IDLE_CYC    = (IDLE_LIMIT_MS * 1000000) / CLK_NS;
    localparam int CYCLE_CYC   = (CYCLE_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int RAS_LOW_CYC = (RAS_WIDTH_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int RAS_PRE_CYC = (RAS_PRE_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int ROW_CYC     = (RAS_CAS_MIN_NS + CLK_NS - 1) / CLK_NS;
    localparam int CAS_LOW_CYC = (ACCESS_CAS_NS + CLK_NS - 1) / CLK_NS;
    localparam int ACC_CYC     = (ACCESS_RAS_NS + CLK_NS - 1) / CLK_NS;
    localparam int ADDR_W      = 9;
    localparam int CNT_W       = 16;
endpackage

// [test/dram_async_cycle_timing_tb_top.sv]
// self-checking bench for the memory controller
// drives the user side at falling mclk; memory model on the pins
module dram_async_cycle_timing_tb_top;
    import dram_timing_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct { logic w; logic [17:0] a; logic d; } row_type;
    logic        mclk = 1'b0;
    logic        rst_b = 1'b0;
    logic        req_valid = 1'b0;
    logic        req_write = 1'b0;
    logic        req_wdata = 1'b0;
    logic [17:0] req_addr = 18'h00000;
    logic        req_ready, rsp_valid, rsp_rdata, init_done;
    logic        ras_b, cas_b, we_b, din, dout;
    logic [8:0]  muxed_address;
    int          miscompares = 0;
    int          num_checks = 0;
    row_type     rows [8] = '{
        '{1'b1, 18'h00000, 1'b1}, '{1'b1, 18'h3FFFF, 1'b1},
        '{1'b1, 18'h001FF, 1'b1}, '{1'b1, 18'h3FE00, 1'b0},
        '{1'b0, 18'h00000, 1'b1}, '{1'b0, 18'h3FE00, 1'b0},
        '{1'b0, 18'h001FF, 1'b1}, '{1'b0, 18'h3FFFF, 1'b1}};
    dram_async_ctrl #(.POWERUP_COUNT(4), .IDLE_COUNT(50)) dut (
        .mclk(mclk), .rst_b(rst_b), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
        .init_done(init_done), .ras_b(ras_b), .cas_b(cas_b), .we_b(we_b),
        .muxed_address(muxed_address), .din(din), .dout(dout));
    dram_mem_model mem (.ras_b(ras_b), .cas_b(cas_b), .we_b(we_b),
        .muxed_address(muxed_address), .din(din), .dout(dout));
    initial forever #50 mclk = ~mclk;
    task automatic check(input logic seen, input logic exp);
        num_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: saw %b want %b", $time, seen, exp);
        end
    endtask
    task automatic set_req(input logic v, w, input logic [17:0] a,
                           input logic d);
        req_valid = v;
        req_write = w;
        req_addr = a;
        req_wdata = d;
    endtask
    task automatic access(input logic w, input logic [17:0] a, input logic d);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 2000) begin
            @(negedge mclk);
            n++;
        end
        check(req_ready, 1'b1);
        set_req(1'b1, w, a, d);
        @(negedge mclk);
        req_valid = 1'b0;
        n = 0;
        while (!w && rsp_valid !== 1'b1 && n < 12) begin
            @(negedge mclk);
            n++;
        end
        if (!w) begin
            check(rsp_valid, 1'b1);
            check(rsp_rdata, d);
        end
    endtask
    task automatic print_verdict();
        if (miscompares == 0 && num_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        int n;
        repeat (16) @(negedge mclk);
        rst_b = 1'b1;
        // offered while not ready, so it must be dropped
        set_req(1'b1, 1'b1, 18'h00005, 1'b1);
        repeat (2) @(negedge mclk);
        req_valid = 1'b0;
        foreach (rows[i]) access(rows[i].w, rows[i].a, rows[i].d);
        access(1'b0, 18'h00005, 1'b0);
        // a write must leave the last read bit alone
        access(1'b1, 18'h00005, 1'b1);
        n = 0;
        while (req_ready !== 1'b1 && n < 40) begin
            @(negedge mclk);
            n++;
        end
        check(rsp_rdata, 1'b0);
        // reset lands in the middle of a read
        set_req(1'b1, 1'b0, 18'h00000, 1'b0);
        repeat (3) @(negedge mclk);
        req_valid = 1'b0;
        rst_b = 1'b0;
        @(negedge mclk);
        check(ras_b & cas_b & we_b, 1'b1);
        check(init_done, 1'b0);
        rst_b = 1'b1;
        access(1'b0, 18'h3FFFF, 1'b1);
        n = 0;
        while (init_done === 1'b1 && n < 200) begin
            @(negedge mclk);
            n++;
        end
        check(init_done, 1'b0);
        access(1'b0, 18'h001FF, 1'b1);
        print_verdict();
    end
    initial begin
        #500000;
        miscompares++;
        print_verdict();
    end
endmodule

// [test/dram_ctrl_chk_sva.sv]
// pin timing checker for the memory controller
// sees only the controller ports; bound at the foot
module dram_ctrl_chk
    import dram_timing_pkg::*;
#(
    parameter int POWERUP_COUNT = POWERUP_CYC,
    parameter int IDLE_COUNT    = IDLE_CYC
) (
    input wire logic              mclk,
    input wire logic              rst_b,
    input wire logic              req_valid,
    input wire logic              req_write,
    input wire logic [17:0]       req_addr,
    input wire logic              req_ready,
    input wire logic              rsp_valid,
    input wire logic              init_done,
    input wire logic              ras_b,
    input wire logic              cas_b,
    input wire logic              we_b,
    input wire logic [ADDR_W-1:0] muxed_address
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [17:0] addr_q;
    logic [15:0] up_cnt;
    logic [3:0]  fall_cnt;
    wire         take = req_valid && req_ready;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rst_b);
    // row fall count restarts whenever init is redone; power-up count only at reset
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            addr_q <= 18'h00000;
            up_cnt <= 16'h0000;
            fall_cnt <= 4'h0;
        end else begin
            if (take)
                addr_q <= req_addr;
            if (up_cnt != 16'hFFFF)
                up_cnt <= up_cnt + 16'h0001;
            if (init_done)
                fall_cnt <= 4'h0;
            else if ($fell(ras_b) && fall_cnt != 4'hF)
                fall_cnt <= fall_cnt + 4'h1;
        end
    end
    a_pwr_wait_first: assert property (
        $fell(ras_b) |-> up_cnt >= POWERUP_COUNT)
        else $error("row strobe before power-up wait");
    a_init_eight_cyc: assert property (
        $rose(init_done) |-> fall_cnt >= 4'h8)
        else $error("init done before eight row pulses");
    a_ras_fall_gap: assert property ($fell(ras_b) |=> (!$fell(ras_b)) [*2])
        else $error("row strobe falls too close");
    a_row_addr_out: assert property (take |-> ##[1:3]
        ($fell(ras_b) && muxed_address == addr_q[8:0]))
        else $error("row address wrong at row strobe");
    a_row_addr_hold: assert property (
        $fell(ras_b) |-> $stable(muxed_address))
        else $error("row address moved at row strobe");
    a_col_addr_out: assert property (take |-> ##[2:5]
        ($fell(cas_b) && muxed_address == addr_q[17:9]))
        else $error("column address wrong at column strobe");
    a_col_addr_hold: assert property ($fell(cas_b) |->
        $stable(muxed_address) ##1 $stable(muxed_address))
        else $error("column address not held");
    a_ras_after_cas: assert property ($fell(cas_b) |-> !ras_b ##1 !ras_b)
        else $error("row strobe rose too soon");
    a_read_we_high: assert property (
        take && !req_write |-> we_b [*6])
        else $error("write strobe low in read");
    a_we_before_ras: assert property (
        $fell(ras_b) |-> we_b && $past(we_b))
        else $error("write strobe low before row strobe");
    a_read_answer: assert property (
        take && !req_write |-> ##[5:8] rsp_valid)
        else $error("read answer late");
    a_ready_drops: assert property (take |=> !req_ready)
        else $error("ready stayed high after take");
    a_ready_off_init: assert property (
        $fell(init_done) |-> !$past(req_ready))
        else $error("ready high as re-init began");
endmodule

bind dram_async_ctrl dram_ctrl_chk #(
    .POWERUP_COUNT(POWERUP_COUNT),
    .IDLE_COUNT(IDLE_COUNT)
) chk (
    .mclk(mclk), .rst_b(rst_b), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_ready(req_ready),
    .rsp_valid(rsp_valid), .init_done(init_done), .ras_b(ras_b),
    .cas_b(cas_b), .we_b(we_b), .muxed_address(muxed_address)
);

// [test/dram_mem_model.sv]
// behavioural 256k x 1 memory on the controller pins
// has no clock; contents survive a controller reset
module dram_mem_model (
    input wire logic       ras_b,
    input wire logic       cas_b,
    input wire logic       we_b,
    input wire logic [8:0] muxed_address,
    input wire logic       din,
    output logic           dout
);
    timeunit 1ns;
    timeprecision 1ps;
    bit         mem [0:262143];
    logic [8:0] row_q;
    logic [8:0] col_q;
    initial dout = 1'b0;
    always @(negedge ras_b) row_q = muxed_address;
    always @(negedge cas_b) begin
        col_q = muxed_address;
        if (!we_b)
            mem[{col_q, row_q}] = din;
        else
            #25 dout = mem[{col_q, row_q}];
    end
    // released line shows the inverse, not the last bit
    always @(posedge cas_b) #20 dout = ~dout;
endmodule
